// ---- rtl/ipc_pkg.sv ----
// package: register map, field positions and reset values of the interrupt priority block
package ipc_pkg;
   localparam logic [11:0] ADDR_PRIO_TWO    = 12'h000;
   localparam logic [11:0] ADDR_RESET_CAUSE = 12'h004;
   localparam logic [11:0] ADDR_MAIN_CTRL   = 12'h008;
   localparam logic [11:0] ADDR_SECOND_CTRL = 12'h00C;
   localparam logic [11:0] ADDR_THIRD_CTRL  = 12'h010;
   localparam logic [11:0] ADDR_PERIPH_FLAG = 12'h014;
   localparam logic [11:0] ADDR_PERIPH_EN   = 12'h018;
   localparam logic [11:0] ADDR_TIMER_LOW   = 12'h01C;
   localparam logic [11:0] ADDR_TIMER_HIGH  = 12'h020;
   localparam logic [11:0] ADDR_TIMER_CTRL  = 12'h024;
   localparam logic [11:0] ADDR_STATUS      = 12'h028;

   localparam logic [7:0]  PRIO_TWO_RESET   = 8'hDF;
   localparam logic [7:0]  PRIO_TWO_MASK    = 8'hDF;
   localparam logic [7:0]  RESET_CAUSE_WMASK = 8'hD3;

   // reset-cause fields
   localparam int RC_PRIO_ON   = 7;
   localparam int RC_SOFT_BROWNOUT_ENABLE    = 6;
   localparam int RC_RI        = 4;
   localparam int RC_TO        = 3;
   localparam int RC_PD        = 2;
   localparam int RC_POR       = 1;
   localparam int RC_BOR       = 0;
   // main control fields
   localparam int MC_GIE       = 7;
   localparam int MC_PERIPHERAL_GLOBAL_ENABLE      = 6;
   localparam int MC_T0_EN     = 5;
   localparam int MC_X0_EN     = 4;
   localparam int MC_PC_EN     = 3;
   localparam int MC_T0_FLAG   = 2;
   localparam int MC_X0_FLAG   = 1;
   localparam int MC_PC_FLAG   = 0;
   // second control fields
   localparam int SC_EDGE0     = 6;
   localparam int SC_EDGE1     = 5;
   localparam int SC_EDGE2     = 4;
   localparam int SC_T0_PRIO   = 2;
   localparam int SC_PC_PRIO   = 0;
   // third control fields
   localparam int TC_X2_PRIO   = 7;
   localparam int TC_X1_PRIO   = 6;
   localparam int TC_X2_EN     = 4;
   localparam int TC_X1_EN     = 3;
   localparam int TC_X2_FLAG   = 1;
   localparam int TC_X1_FLAG   = 0;
   // timer control fields
   localparam int TM_ON        = 7;
   localparam int TM_16BIT     = 6;

   localparam logic [7:0] MAIN_CTRL_RESET   = 8'h00;
   localparam logic [7:0] SECOND_CTRL_RESET = 8'hF5;
   localparam logic [7:0] THIRD_CTRL_RESET  = 8'hC0;
   localparam logic [7:0] TIMER_CTRL_RESET  = 8'h00;
   localparam logic [7:0] RESET_CAUSE_FIXED = 8'h1C;

   typedef enum logic [2:0] {
      IPC_RUN   = 3'b001,
      IPC_SLEEP = 3'b010,
      IPC_ENTRY = 3'b100
   } ipc_state_type;
endpackage

// ---- rtl/ipc_interrupt_priority.sv ----
// interrupt priority, external pin, timer overflow and port change logic with apb registers
//
// Implementation choices: the register offsets and register access over APB.
module ipc_interrupt_priority (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  ext_pins,
   input  wire logic [3:0]  port_b_pins,
   input  wire logic [7:0]  periph_events,
   input  wire logic        cfg_soft_brownout_enable_reset,
   input  wire logic        cfg_por_reset,
   input  wire logic        reset_instr_event,
   input  wire logic        watchdog_event,
   input  wire logic        sleep_event,
   input  wire logic        sleep_req,
   input  wire logic        irq_ack,
   input  wire logic [15:0] return_pc,
   input  wire logic [7:0]  working_register,
   input  wire logic [7:0]  status_reg,
   input  wire logic [7:0]  bank_select_register,
   output logic             irq_high,
   output logic             irq_low,
   output logic             wake,
   output logic             entry_strobe,
   output logic      [15:0] stack_top,
   output logic      [7:0]  shadow_working,
   output logic      [7:0]  shadow_status,
   output logic      [7:0]  shadow_bank
);
   import ipc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]  peripheral_priority_two;
   logic [7:0]  reset_cause_and_priority_enable;
   logic [7:0]  main_irq_control;
   logic [7:0]  second_irq_control;
   logic [7:0]  third_irq_control;
   logic [7:0]  periph_flag;
   logic [7:0]  periph_en;
   logic [7:0]  timer_ctrl;
   logic [15:0] timer_zero_counter;
   logic [2:0]  ext_q;
   logic [3:0]  port_q;
   logic        cfg_taken;
   ipc_state_type state;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire bus_wr  = psel & penable & pwrite;
   wire bus_rd  = psel & ~pwrite;
   wire hit_p2  = paddr == ADDR_PRIO_TWO;
   wire hit_rc  = paddr == ADDR_RESET_CAUSE;
   wire hit_mc  = paddr == ADDR_MAIN_CTRL;
   wire hit_sc  = paddr == ADDR_SECOND_CTRL;
   wire hit_tc  = paddr == ADDR_THIRD_CTRL;
   wire hit_pf  = paddr == ADDR_PERIPH_FLAG;
   wire hit_pe  = paddr == ADDR_PERIPH_EN;
   wire hit_tl  = paddr == ADDR_TIMER_LOW;
   wire hit_th  = paddr == ADDR_TIMER_HIGH;
   wire hit_tm  = paddr == ADDR_TIMER_CTRL;
   wire hit_st  = paddr == ADDR_STATUS;
   wire hit_any = hit_p2 | hit_rc | hit_mc | hit_sc | hit_tc | hit_pf | hit_pe
                  | hit_tl | hit_th | hit_tm | hit_st;
   wire [7:0] wbyte = pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // edge and change detection on registered levels
   wire [2:0] edge_sel = {second_irq_control[SC_EDGE2], second_irq_control[SC_EDGE1],
                          second_irq_control[SC_EDGE0]};
   wire [2:0] ext_rise = ext_pins & ~ext_q;
   wire [2:0] ext_fall = ~ext_pins & ext_q;
   // no edges before the first sample after reset: a pin may already sit high
   wire [2:0] ext_hit  = {3{cfg_taken}} & ((edge_sel & ext_rise) | (~edge_sel & ext_fall));
   wire       port_hit = cfg_taken & (|(port_b_pins ^ port_q));

   // timer overflow; 16-bit mode only rolls the pair
   wire        tmr_on   = timer_ctrl[TM_ON];
   wire        tmr_16   = timer_ctrl[TM_16BIT];
   wire [15:0] tmr_next = timer_zero_counter + 16'h0001;
   wire        tmr_ovf  = tmr_on & (tmr_16 ? (timer_zero_counter == 16'hFFFF)
                                           : (timer_zero_counter[7:0] == 8'hFF));

   ////////////////////////////////////////////////////////////////////////////
   // request qualification
   wire prio_on = reset_cause_and_priority_enable[RC_PRIO_ON];
   wire global_irq_enable     = main_irq_control[MC_GIE];
   wire peripheral_global_enable    = main_irq_control[MC_PERIPHERAL_GLOBAL_ENABLE];
   wire req_x0  = main_irq_control[MC_X0_FLAG] & main_irq_control[MC_X0_EN];
   wire req_x1  = third_irq_control[TC_X1_FLAG] & third_irq_control[TC_X1_EN];
   wire req_x2  = third_irq_control[TC_X2_FLAG] & third_irq_control[TC_X2_EN];
   wire req_t0  = main_irq_control[MC_T0_FLAG] & main_irq_control[MC_T0_EN];
   wire req_pc  = main_irq_control[MC_PC_FLAG] & main_irq_control[MC_PC_EN];
   wire [7:0] req_pf = periph_flag & periph_en & PRIO_TWO_MASK;
   // pin zero has no priority bit: always high
   wire hi_core = req_x0
                  | (req_x1 & third_irq_control[TC_X1_PRIO])
                  | (req_x2 & third_irq_control[TC_X2_PRIO])
                  | (req_t0 & second_irq_control[SC_T0_PRIO])
                  | (req_pc & second_irq_control[SC_PC_PRIO]);
   wire lo_core = (req_x1 & ~third_irq_control[TC_X1_PRIO])
                  | (req_x2 & ~third_irq_control[TC_X2_PRIO])
                  | (req_t0 & ~second_irq_control[SC_T0_PRIO])
                  | (req_pc & ~second_irq_control[SC_PC_PRIO]);
   wire hi_per  = |(req_pf & peripheral_priority_two);
   wire lo_per  = |(req_pf & ~peripheral_priority_two);
   // single level: all sources on the high line, peripherals gated by peripheral_global_enable
   wire any_core = req_x0 | req_x1 | req_x2 | req_t0 | req_pc;
   wire any_per  = |req_pf;
   wire single_req = global_irq_enable & (any_core | (peripheral_global_enable & any_per));
   // in priority mode gie enables high, low needs both gie and peripheral_global_enable
   wire hi_req  = prio_on ? global_irq_enable & (hi_core | hi_per) : single_req;
   wire lo_req  = prio_on & global_irq_enable & peripheral_global_enable & ~hi_req & (lo_core | lo_per);
   wire wake_src = |(ext_hit & {third_irq_control[TC_X2_EN], third_irq_control[TC_X1_EN],
                                main_irq_control[MC_X0_EN]});

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   wire [7:0] rc_view = reset_cause_and_priority_enable & ~8'h20;
   wire [7:0] st_view = {5'h00, state == IPC_SLEEP, irq_high, irq_low};
   wire [7:0] rd_byte = hit_p2 ? (peripheral_priority_two & PRIO_TWO_MASK) :
                        hit_rc ? rc_view :
                        hit_mc ? main_irq_control :
                        hit_sc ? second_irq_control :
                        hit_tc ? third_irq_control :
                        hit_pf ? periph_flag :
                        hit_pe ? periph_en :
                        hit_tl ? timer_zero_counter[7:0] :
                        hit_th ? timer_zero_counter[15:8] :
                        hit_tm ? timer_ctrl :
                        hit_st ? st_view : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
         prdata  <= (bus_rd & ~penable) ? {24'h000000, rd_byte} : prdata;
      end
   end
   // no wait state: access phase sees pready one cycle after setup
   wire wr_take = bus_wr & pready;

   ////////////////////////////////////////////////////////////////////////////
   // priority and reset-cause registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peripheral_priority_two <= PRIO_TWO_RESET;
         reset_cause_and_priority_enable <= RESET_CAUSE_FIXED;
         cfg_taken <= 1'b0;
      end else begin
         if (wr_take & hit_p2)
            peripheral_priority_two <= wbyte & PRIO_TWO_MASK;
         if (!cfg_taken) begin
            // strap-like reset values caught after release
            cfg_taken <= 1'b1;
            reset_cause_and_priority_enable[RC_SOFT_BROWNOUT_ENABLE] <= cfg_soft_brownout_enable_reset;
            reset_cause_and_priority_enable[RC_POR]    <= cfg_por_reset;
         end else if (wr_take & hit_rc) begin
            reset_cause_and_priority_enable <= (wbyte & RESET_CAUSE_WMASK)
               | (reset_cause_and_priority_enable & ~RESET_CAUSE_WMASK & ~8'h10)
               | (wbyte & 8'h10);
         end
         // hardware events win over software writes
         if (reset_instr_event)
            reset_cause_and_priority_enable[RC_RI] <= 1'b0;
         if (watchdog_event)
            reset_cause_and_priority_enable[RC_TO] <= 1'b0;
         if (sleep_event)
            reset_cause_and_priority_enable[RC_PD] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers and flags; a set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_irq_control   <= MAIN_CTRL_RESET;
         second_irq_control <= SECOND_CTRL_RESET;
         third_irq_control  <= THIRD_CTRL_RESET;
         periph_flag        <= 8'h00;
         periph_en          <= 8'h00;
         timer_ctrl         <= TIMER_CTRL_RESET;
         timer_zero_counter <= 16'h0000;
         ext_q              <= 3'b000;
         port_q             <= 4'h0;
      end else begin
         ext_q  <= ext_pins;
         port_q <= port_b_pins;
         if (wr_take & hit_mc)
            main_irq_control <= wbyte;
         if (wr_take & hit_sc)
            second_irq_control <= wbyte;
         if (wr_take & hit_tc)
            third_irq_control <= wbyte;
         if (wr_take & hit_pe)
            periph_en <= wbyte & PRIO_TWO_MASK;
         if (wr_take & hit_tm)
            timer_ctrl <= wbyte;
         if (wr_take & hit_tl)
            timer_zero_counter[7:0] <= wbyte;
         else if (wr_take & hit_th)
            timer_zero_counter[15:8] <= wbyte;
         else if (tmr_on)
            timer_zero_counter <= tmr_16 ? tmr_next
                                 : {timer_zero_counter[15:8], tmr_next[7:0]};
         // hardware only ever sets flags; software writes can set or clear them
         if (ext_hit[0])
            main_irq_control[MC_X0_FLAG] <= 1'b1;
         if (ext_hit[1])
            third_irq_control[TC_X1_FLAG] <= 1'b1;
         if (ext_hit[2])
            third_irq_control[TC_X2_FLAG] <= 1'b1;
         if (tmr_ovf)
            main_irq_control[MC_T0_FLAG] <= 1'b1;
         if (port_hit)
            main_irq_control[MC_PC_FLAG] <= 1'b1;
         periph_flag <= ((wr_take & hit_pf) ? (wbyte & PRIO_TWO_MASK) : periph_flag)
                        | (periph_events & PRIO_TWO_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core sequencer side: sleep, wake and entry
   wire any_req = hi_req | lo_req;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state          <= IPC_RUN;
         irq_high       <= 1'b0;
         irq_low        <= 1'b0;
         wake           <= 1'b0;
         entry_strobe   <= 1'b0;
         stack_top      <= 16'h0000;
         shadow_working <= 8'h00;
         shadow_status  <= 8'h00;
         shadow_bank    <= 8'h00;
      end else begin
         irq_high     <= hi_req & (state == IPC_RUN);
         irq_low      <= lo_req & (state == IPC_RUN);
         wake         <= 1'b0;
         entry_strobe <= 1'b0;
         unique case (state)
            IPC_RUN: begin
               if (irq_ack & any_req) begin
                  state <= IPC_ENTRY;
               end else if (sleep_req) begin
                  state <= IPC_SLEEP;
               end
            end
            IPC_SLEEP: begin
               // enable state at the edge decides; gie only decides vectoring
               if (wake_src) begin
                  wake  <= 1'b1;
                  state <= IPC_RUN;
               end
            end
            IPC_ENTRY: begin
               entry_strobe   <= 1'b1;
               stack_top      <= return_pc;
               shadow_working <= working_register;
               shadow_status  <= status_reg;
               shadow_bank    <= bank_select_register;
               state          <= IPC_RUN;
            end
         endcase
      end
   end
endmodule

// ---- tb/ipc_interrupt_priority_assertions.sv ----
// checker: bus answer and interrupt entry timing of the priority block
module ipc_interrupt_priority_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq_ack,
   input wire logic [15:0] return_pc,
   input wire logic [7:0]  working_register,
   input wire logic [7:0]  status_reg,
   input wire logic [7:0]  bank_select_register,
   input wire logic        wake,
   input wire logic        entry_strobe,
   input wire logic [15:0] stack_top,
   input wire logic [7:0]  shadow_working,
   input wire logic [7:0]  shadow_status,
   input wire logic [7:0]  shadow_bank
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   //////////////////////////////////////////////////////////////////
   a_ready_access: assert property (psel && penable |-> pready)
      else $error("no answer in access phase");
   a_ready_outside: assert property (!(psel && penable) |-> !pready)
      else $error("answer outside access phase");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without answer");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("read data upper lanes not zero");
   a_entry_after_ack: assert property (entry_strobe |-> $past(irq_ack, 2))
      else $error("entry without acknowledge two cycles before");
   a_entry_capture: assert property (entry_strobe |->
      stack_top == $past(return_pc) && shadow_working == $past(working_register))
      else $error("context capture wrong");
   a_entry_shadow: assert property (entry_strobe |->
      shadow_status == $past(status_reg) && shadow_bank == $past(bank_select_register))
      else $error("status or bank capture wrong");
   a_stack_hold: assert property ($changed(stack_top) |-> entry_strobe)
      else $error("saved return address moved outside entry");
   a_entry_single: assert property (entry_strobe |=> !entry_strobe)
      else $error("entry strobe longer than one cycle");
   a_wake_single: assert property (wake |=> !wake)
      else $error("wake pulse longer than one cycle");
endmodule

bind ipc_interrupt_priority ipc_interrupt_priority_assertions i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
   .return_pc(return_pc), .working_register(working_register), .status_reg(status_reg),
   .bank_select_register(bank_select_register), .wake(wake),
   .entry_strobe(entry_strobe), .stack_top(stack_top), .shadow_working(shadow_working),
   .shadow_status(shadow_status), .shadow_bank(shadow_bank));

// ---- tb/ipc_core_model.sv ----
// model: core sequencer that accepts requests and offers context
module ipc_core_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        irq_high,
   input  wire logic        irq_low,
   input  wire logic        entry_strobe,
   input  wire logic        ack_on,
   output logic             irq_ack,
   output logic      [15:0] return_pc,
   output logic      [7:0]  working_register,
   output logic      [7:0]  status_reg,
   output logic      [7:0]  bank_select_register
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy;
   // context moves after each entry so a stale capture shows
   assign working_register     = return_pc[7:0] ^ 8'h5A;
   assign status_reg           = return_pc[15:8];
   assign bank_select_register = ~return_pc[7:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ack   <= 1'b0;
         busy      <= 1'b0;
         return_pc <= 16'h1230;
      end else begin
         irq_ack <= ack_on && !busy && !irq_ack && (irq_high || irq_low);
         busy    <= (busy || irq_ack) && !entry_strobe;
         if (entry_strobe) begin
            return_pc <= return_pc + 16'h0004;
         end
      end
   end
endmodule

// ---- tb/tb.sv ----
// testbench: register, pin, timer, sleep and entry sequences
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, pready, pslverr, irq_ack, irq_high, irq_low, wake, entry_strobe;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        cfg_soft_brownout_enable_reset = 1'b1, cfg_por_reset = 1'b0, sleep_req = 1'b0;
   logic        reset_instr_event = 1'b0, watchdog_event = 1'b0, sleep_event = 1'b0;
   logic        ack_on = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic [2:0]  ext_pins = 3'h0;
   logic [3:0]  port_b_pins = 4'h0;
   logic [7:0]  periph_events = 8'h00, q, working_register, status_reg;
   logic [7:0]  bank_select_register, shadow_working, shadow_status, shadow_bank;
   logic [15:0] return_pc, stack_top;
   int          error_cnt = 0, n_compared = 0;

   ipc_interrupt_priority i_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_pins(ext_pins), .port_b_pins(port_b_pins), .periph_events(periph_events),
      .cfg_soft_brownout_enable_reset(cfg_soft_brownout_enable_reset), .cfg_por_reset(cfg_por_reset),
      .reset_instr_event(reset_instr_event), .watchdog_event(watchdog_event),
      .sleep_event(sleep_event), .sleep_req(sleep_req), .irq_ack(irq_ack),
      .return_pc(return_pc), .working_register(working_register), .status_reg(status_reg),
      .bank_select_register(bank_select_register), .irq_high(irq_high), .irq_low(irq_low),
      .wake(wake), .entry_strobe(entry_strobe), .stack_top(stack_top),
      .shadow_working(shadow_working), .shadow_status(shadow_status),
      .shadow_bank(shadow_bank));
   ipc_core_model i_core (
      .pclk(pclk), .presetn(presetn), .irq_high(irq_high), .irq_low(irq_low),
      .entry_strobe(entry_strobe), .ack_on(ack_on), .irq_ack(irq_ack),
      .return_pc(return_pc), .working_register(working_register), .status_reg(status_reg),
      .bank_select_register(bank_select_register));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   //////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] s, e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         finish_test();
      end
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // retries cover flag latency; a wrong static value still times out
   task automatic poll(input logic [11:0] a, input logic [7:0] m, e);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 8'h00);
         n++;
      end while ((q & m) !== e && n < 300);
      chk($sformatf("addr %h", a), q & m, e);
      if ((q & m) !== e) begin
         finish_test();
      end
   endtask

   task automatic waitsig(ref logic s);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (s !== 1'b1 && n < 100);
      chk("pulse", {7'h00, s}, 8'h01);
      if (s !== 1'b1) begin
         finish_test();
      end
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      poll(12'h000, 8'hFF, 8'hDF);
      apb(1'b1, 12'h000, 8'h00);
      poll(12'h000, 8'hFF, 8'h00);
      apb(1'b1, 12'h000, 8'hFF);
      poll(12'h000, 8'hFF, 8'hDF);
      poll(12'h004, 8'hFF, 8'h5C);
      apb(1'b1, 12'h004, 8'hFF);
      poll(12'h004, 8'hFF, 8'hDF);
      apb(1'b1, 12'h004, 8'h00);
      poll(12'h004, 8'hFF, 8'h0C);
      @(posedge pclk);
      {reset_instr_event, watchdog_event, sleep_event} <= 3'b111;
      periph_events <= 8'hFF;
      @(posedge pclk);
      {reset_instr_event, watchdog_event, sleep_event} <= 3'b000;
      periph_events <= 8'h00;
      poll(12'h004, 8'hFF, 8'h00);
      poll(12'h014, 8'hFF, 8'hDF);
      apb(1'b1, 12'h004, 8'h80);
      apb(1'b0, 12'h030, 8'h00);
      chk("slverr", {7'h00, err}, 8'h01);
      chk("unmapped", q, 8'h00);
      apb(1'b1, 12'h008, 8'h90);
      ext_pins[0] <= 1'b1;
      poll(12'h028, 8'h03, 8'h02);
      poll(12'h008, 8'hFF, 8'h92);
      ack_on <= 1'b1;
      waitsig(entry_strobe);
      apb(1'b1, 12'h008, 8'h90);
      ack_on <= 1'b0;
      poll(12'h028, 8'h03, 8'h00);
      apb(1'b1, 12'h008, 8'h80);
      apb(1'b1, 12'h00C, 8'hB5);
      ext_pins[0] <= 1'b0;
      poll(12'h008, 8'hFF, 8'h82);
      poll(12'h028, 8'h03, 8'h00);
      apb(1'b1, 12'h008, 8'hC0);
      apb(1'b1, 12'h010, 8'h08);
      ext_pins[1] <= 1'b1;
      poll(12'h028, 8'h03, 8'h01);
      apb(1'b1, 12'h010, 8'h49);
      poll(12'h028, 8'h03, 8'h02);
      apb(1'b1, 12'h010, 8'h08);
      apb(1'b1, 12'h00C, 8'hF4);
      apb(1'b1, 12'h008, 8'hC8);
      port_b_pins[2] <= 1'b1;
      poll(12'h008, 8'h01, 8'h01);
      poll(12'h028, 8'h03, 8'h01);
      apb(1'b1, 12'h008, 8'h00);
      apb(1'b1, 12'h01C, 8'hF0);
      apb(1'b1, 12'h024, 8'h80);
      poll(12'h008, 8'h04, 8'h04);
      apb(1'b1, 12'h024, 8'h00);
      apb(1'b1, 12'h008, 8'h00);
      apb(1'b1, 12'h020, 8'h00);
      apb(1'b1, 12'h01C, 8'hF0);
      apb(1'b1, 12'h024, 8'hC0);
      poll(12'h020, 8'hFF, 8'h01);
      poll(12'h008, 8'h04, 8'h00);
      apb(1'b1, 12'h024, 8'h00);
      apb(1'b1, 12'h008, 8'hA0);
      apb(1'b1, 12'h020, 8'hFF);
      apb(1'b1, 12'h01C, 8'hF0);
      apb(1'b1, 12'h024, 8'hC0);
      poll(12'h008, 8'h04, 8'h04);
      poll(12'h028, 8'h03, 8'h02);
      apb(1'b1, 12'h024, 8'h00);
      apb(1'b1, 12'h008, 8'h00);
      apb(1'b1, 12'h004, 8'h00);
      apb(1'b1, 12'h018, 8'h01);
      apb(1'b1, 12'h008, 8'h80);
      poll(12'h028, 8'h03, 8'h00);
      apb(1'b1, 12'h008, 8'hC0);
      poll(12'h028, 8'h03, 8'h02);
      apb(1'b1, 12'h018, 8'h00);
      apb(1'b1, 12'h008, 8'h00);
      ext_pins[1] <= 1'b0;
      @(posedge pclk);
      sleep_req <= 1'b1;
      @(posedge pclk);
      sleep_req <= 1'b0;
      poll(12'h028, 8'h04, 8'h04);
      ext_pins[1] <= 1'b1;
      waitsig(wake);
      poll(12'h028, 8'h07, 8'h00);
      // mid-run reset with pins left high: no false edge may follow
      @(posedge pclk);
      presetn <= 1'b0;
      {cfg_soft_brownout_enable_reset, cfg_por_reset} <= 2'b01;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      poll(12'h004, 8'hFF, 8'h1E);
      poll(12'h000, 8'hFF, 8'hDF);
      poll(12'h010, 8'hFF, 8'hC0);
      poll(12'h008, 8'hFF, 8'h00);
      finish_test();
   end
endmodule
